// [design/ipo_pkg.sv]
/*
 inclination profile output: object indexes, subindexes, field bits and
 reset values shared by the output stage and its bench.
 assumes a 16-bit object dictionary port driven by the node's protocol logic.
*/
package ipo_pkg;
   // ==========================================================
   // object indexes
   localparam logic [15:0] IDX_RESOLUTION = 16'h6000;
   localparam logic [15:0] IDX_X_OUTPUT   = 16'h6010;
   localparam logic [15:0] IDX_X_OPBITS   = 16'h6011;
   localparam logic [15:0] IDX_X_PRESET   = 16'h6012;
   localparam logic [15:0] IDX_X_OFFSET   = 16'h6013;
   localparam logic [15:0] IDX_Y_OUTPUT   = 16'h6020;
   localparam logic [15:0] IDX_Y_OPBITS   = 16'h6021;
   localparam logic [15:0] IDX_Y_PRESET   = 16'h6022;
   localparam logic [15:0] IDX_Y_OFFSET   = 16'h6023;
   localparam logic [15:0] IDX_ARRAY      = 16'h6401;
   localparam logic [15:0] IDX_DEV_TEMP   = 16'h6511;

   // ==========================================================
   // subindexes: plain objects and the sensor output array
   localparam logic [7:0] SUB_PLAIN     = 8'h00;
   localparam logic [7:0] SUB_COUNT     = 8'h00;
   localparam logic [7:0] SUB_ACCEL_X   = 8'h01;
   localparam logic [7:0] SUB_ACCEL_Y   = 8'h02;
   localparam logic [7:0] SUB_ACCEL_Z   = 8'h03;
   localparam logic [7:0] SUB_TILT_X    = 8'h04;
   localparam logic [7:0] SUB_TILT_Y    = 8'h05;
   localparam logic [7:0] SUB_TEMP      = 8'h0a;
   localparam logic [7:0] SUB_FULL_X    = 8'h0e;
   localparam logic [7:0] SUB_HIGHEST   = 8'h0f;

   // ==========================================================
   // resolution codes and their step in 0.01 degree units
   localparam logic [15:0] RES_HUNDREDTH = 16'h000a;
   localparam logic [15:0] RES_TENTH     = 16'h0064;
   localparam logic [15:0] RES_WHOLE     = 16'h03e8;
   localparam logic signed [31:0] STEP_HUNDREDTH = 32'sh00000001;
   localparam logic signed [31:0] STEP_TENTH     = 32'sh0000000a;
   localparam logic signed [31:0] STEP_WHOLE     = 32'sh00000064;

   // ==========================================================
   // operating bits and reset values
   localparam int          OP_INVERT_BIT = 0;
   localparam int          OP_PRESET_BIT = 1;
   localparam logic [7:0]  OP_RESET      = 8'h02;
   localparam logic [15:0] PRESET_RESET  = 16'h0000;
   localparam logic [15:0] ZERO_WORD     = 16'h0000;

   // ==========================================================
   // saturation bounds and the preset offset limit (5 degrees)
   localparam logic signed [31:0] SAT_MAX      = 32'sh00007fff;
   localparam logic signed [31:0] SAT_MIN      = -32'sh00008000;
   localparam logic signed [31:0] OFFSET_LIMIT = 32'sh000001f4;
endpackage

// [design/ipo_core.sv]
/*
 inclination profile output stage: resolution, per-axis operating bits,
 preset and offset entries, signed tilt outputs and the sensor output array,
 all reached through a one-word object dictionary request port.
 assumes measurement inputs and requests come from logic on core_clk, the
 measurements already in 0.01 degree (tilt) and profile units (others).
*/
// How it works
// - resolution entry selects 0.01, 0.1 or 1.0 degree steps, default 0.01
// - x tilt output is read-only signed 16 bits in selected resolution
// - y tilt output is read-only signed 16 bits, same resolution as x
// - operating bit 0 inverts the axis direction when set
// - operating bit 1 decides whether preset correction applies to the axis
// - operating bits reset to preset enabled, inversion disabled
// - with correction enabled the output adds the axis offset entry to the measured tilt
// - with correction disabled the output is the measured tilt after any bit 0 inversion, without the offset
// - preset entries are signed, in resolution units; with correction enabled the axis output then reads the preset
// - a preset stores the resulting offset in the axis offset entry
// - loading defaults zeroes presets and restores factory offsets
// - narrow two-axis units accept a preset only if its resulting offset is within plus or minus 5 degrees
// - output array reports fifteen as its highest subindex, read-only
// - acceleration channels are read-only signed 16 bits in 1 mg steps
// - full circle x tilt is unsigned 16 bits in 0.01 degree steps
// - settings stay volatile until the master triggers a store
// - array tilt channels equal the axis outputs at 0.01 degree steps
// - reserved array channels read back as zero
`timescale 1ns/1ps
module ipo_core #(
   parameter logic [15:0] FACTORY_OFFSET_X = 16'h0000,
   parameter logic [15:0] FACTORY_OFFSET_Y = 16'h0000,
   parameter logic        NARROW_TWO_AXIS  = 1'b0
) (
   input  wire logic        core_clk,
   input  wire logic        rst,
   input  wire logic        od_req,
   input  wire logic        od_write,
   input  wire logic [15:0] od_index,
   input  wire logic [7:0]  od_sub,
   input  wire logic [15:0] od_wdata,
   output logic      [15:0] od_rdata,
   output logic             od_ack,
   output logic             od_err,
   input  wire logic        load_defaults,
   input  wire logic        store_done,
   output logic             settings_dirty,
   input  wire logic [15:0] meas_tilt_x,
   input  wire logic [15:0] meas_tilt_y,
   input  wire logic [15:0] meas_accel_x,
   input  wire logic [15:0] meas_accel_y,
   input  wire logic [15:0] meas_accel_z,
   input  wire logic [15:0] meas_temp_tenth,
   input  wire logic [15:0] meas_full_x,
   input  wire logic [15:0] meas_dev_temp,
   output logic      [15:0] tilt_x_out,
   output logic      [15:0] tilt_y_out
);

   // ==========================================================
   // state
   typedef struct packed {
      logic [15:0] res;
      logic [7:0]  op_x;
      logic [7:0]  op_y;
      logic [15:0] pre_x;
      logic [15:0] pre_y;
      logic [15:0] off_x;
      logic [15:0] off_y;
      logic [15:0] out_x;
      logic [15:0] out_y;
      logic [15:0] arr_x;
      logic [15:0] arr_y;
      logic [15:0] rdata;
      logic        ack;
      logic        err;
      logic        dirty;
   } ipo_state_t;

   ipo_state_t st_reg;
   ipo_state_t st_next;

   // ==========================================================
   // arithmetic helpers
   function automatic logic [15:0] ipo_sat16(input logic signed [31:0] v);
      if (v > ipo_pkg::SAT_MAX) begin
         return ipo_pkg::SAT_MAX[15:0];
      end
      if (v < ipo_pkg::SAT_MIN) begin
         return ipo_pkg::SAT_MIN[15:0];
      end
      return v[15:0];
   endfunction

   // step of one output count in 0.01 degree units
   function automatic logic signed [31:0] ipo_step(input logic [15:0] res);
      unique case (res)
         ipo_pkg::RES_TENTH: return ipo_pkg::STEP_TENTH;
         ipo_pkg::RES_WHOLE: return ipo_pkg::STEP_WHOLE;
         default:            return ipo_pkg::STEP_HUNDREDTH;
      endcase
   endfunction

   function automatic logic ipo_res_legal(input logic [15:0] code);
      return (code == ipo_pkg::RES_HUNDREDTH) || (code == ipo_pkg::RES_TENTH) ||
             (code == ipo_pkg::RES_WHOLE);
   endfunction

   // measured value after the direction choice
   function automatic logic signed [31:0] ipo_dir(input logic [15:0] raw,
                                                  input logic [7:0]  op);
      logic signed [31:0] v;
      v = 32'(signed'(raw));
      return op[ipo_pkg::OP_INVERT_BIT] ? -v : v;
   endfunction

   // inversion, then offset, then scaling
   function automatic logic [15:0] ipo_axis(input logic [15:0] raw,
                                            input logic [7:0]  op,
                                            input logic [15:0] off,
                                            input logic signed [31:0] step);
      logic signed [31:0] v;
      v = ipo_dir(raw, op);
      if (op[ipo_pkg::OP_PRESET_BIT]) begin
         v = v + 32'(signed'(off));
      end
      // truncation toward zero keeps the output symmetric about zero
      return ipo_sat16(v / step);
   endfunction

   // offset that makes the axis read the preset at the present position
   function automatic logic signed [31:0] ipo_offset(input logic [15:0] pre,
                                                     input logic [15:0] raw,
                                                     input logic [7:0]  op,
                                                     input logic signed [31:0] step);
      return 32'(signed'(pre)) * step - ipo_dir(raw, op);
   endfunction

   function automatic logic ipo_in_limit(input logic signed [31:0] off);
      return !NARROW_TWO_AXIS || ((off <= ipo_pkg::OFFSET_LIMIT) &&
                                  (off >= -ipo_pkg::OFFSET_LIMIT));
   endfunction

   // ==========================================================
   // request decode
   logic               rd;
   logic               wr;
   logic               sub_plain;
   logic signed [31:0] step_now;
   logic signed [31:0] new_off_x;
   logic signed [31:0] new_off_y;

   assign rd        = od_req && !od_write;
   assign wr        = od_req && od_write;
   assign sub_plain = (od_sub == ipo_pkg::SUB_PLAIN);
   assign step_now  = ipo_step(st_reg.res);
   // presets are taken in the resolution in force when written
   assign new_off_x = ipo_offset(od_wdata, meas_tilt_x, st_reg.op_x, step_now);
   assign new_off_y = ipo_offset(od_wdata, meas_tilt_y, st_reg.op_y, step_now);

   // ==========================================================
   // next state
   always_comb begin
      logic        hit;
      logic        ok;
      logic [15:0] rv;
      hit = 1'b0;
      ok  = 1'b0;
      rv  = ipo_pkg::ZERO_WORD;
      st_next       = st_reg;
      st_next.ack   = od_req;
      st_next.err   = 1'b0;
      st_next.rdata = ipo_pkg::ZERO_WORD;

      // outputs follow the measurement every cycle
      st_next.out_x = ipo_axis(meas_tilt_x, st_reg.op_x, st_reg.off_x, step_now);
      st_next.out_y = ipo_axis(meas_tilt_y, st_reg.op_y, st_reg.off_y, step_now);
      st_next.arr_x = ipo_axis(meas_tilt_x, st_reg.op_x, st_reg.off_x,
                               ipo_pkg::STEP_HUNDREDTH);
      st_next.arr_y = ipo_axis(meas_tilt_y, st_reg.op_y, st_reg.off_y,
                               ipo_pkg::STEP_HUNDREDTH);

      // read mux; reserved array channels fall through as zero
      if (rd) begin
         if (od_index == ipo_pkg::IDX_ARRAY) begin
            hit = (od_sub <= ipo_pkg::SUB_HIGHEST);
            unique case (od_sub)
               ipo_pkg::SUB_COUNT:   rv = {8'h00, ipo_pkg::SUB_HIGHEST};
               ipo_pkg::SUB_ACCEL_X: rv = meas_accel_x;
               ipo_pkg::SUB_ACCEL_Y: rv = meas_accel_y;
               ipo_pkg::SUB_ACCEL_Z: rv = meas_accel_z;
               ipo_pkg::SUB_TILT_X:  rv = st_reg.arr_x;
               ipo_pkg::SUB_TILT_Y:  rv = st_reg.arr_y;
               ipo_pkg::SUB_TEMP:    rv = meas_temp_tenth;
               ipo_pkg::SUB_FULL_X:  rv = meas_full_x;
               default:              rv = ipo_pkg::ZERO_WORD;
            endcase
         end else if (sub_plain) begin
            hit = 1'b1;
            unique case (od_index)
               ipo_pkg::IDX_RESOLUTION: rv = st_reg.res;
               ipo_pkg::IDX_X_OUTPUT:   rv = st_reg.out_x;
               ipo_pkg::IDX_X_OPBITS:   rv = {8'h00, st_reg.op_x};
               ipo_pkg::IDX_X_PRESET:   rv = st_reg.pre_x;
               ipo_pkg::IDX_X_OFFSET:   rv = st_reg.off_x;
               ipo_pkg::IDX_Y_OUTPUT:   rv = st_reg.out_y;
               ipo_pkg::IDX_Y_OPBITS:   rv = {8'h00, st_reg.op_y};
               ipo_pkg::IDX_Y_PRESET:   rv = st_reg.pre_y;
               ipo_pkg::IDX_Y_OFFSET:   rv = st_reg.off_y;
               ipo_pkg::IDX_DEV_TEMP:   rv = meas_dev_temp;
               default: begin
                  hit = 1'b0;
                  rv  = ipo_pkg::ZERO_WORD;
               end
            endcase
         end
         st_next.rdata = rv;
         st_next.err   = !hit;
      end

      // writes; outputs and the array are refused as read-only
      if (wr) begin
         if (sub_plain) begin
            unique case (od_index)
               ipo_pkg::IDX_RESOLUTION: begin
                  ok = ipo_res_legal(od_wdata);
                  if (ok) begin
                     st_next.res = od_wdata;
                  end
               end
               ipo_pkg::IDX_X_OPBITS: begin
                  ok = (od_wdata[15:8] == 8'h00);
                  if (ok) begin
                     st_next.op_x = od_wdata[7:0];
                  end
               end
               ipo_pkg::IDX_Y_OPBITS: begin
                  ok = (od_wdata[15:8] == 8'h00);
                  if (ok) begin
                     st_next.op_y = od_wdata[7:0];
                  end
               end
               ipo_pkg::IDX_X_PRESET: begin
                  ok = ipo_in_limit(new_off_x);
                  if (ok) begin
                     st_next.pre_x = od_wdata;
                     st_next.off_x = ipo_sat16(new_off_x);
                  end
               end
               ipo_pkg::IDX_Y_PRESET: begin
                  ok = ipo_in_limit(new_off_y);
                  if (ok) begin
                     st_next.pre_y = od_wdata;
                     st_next.off_y = ipo_sat16(new_off_y);
                  end
               end
               ipo_pkg::IDX_X_OFFSET: begin
                  ok = 1'b1;
                  st_next.off_x = od_wdata;
               end
               ipo_pkg::IDX_Y_OFFSET: begin
                  ok = 1'b1;
                  st_next.off_y = od_wdata;
               end
               default: ok = 1'b0;
            endcase
         end
         st_next.err = !ok;
      end

      // volatile until stored; a new change beats a store acknowledge
      if (store_done) begin
         st_next.dirty = 1'b0;
      end
      if (wr && ok) begin
         st_next.dirty = 1'b1;
      end

      // default load overrides any write of the same cycle
      if (load_defaults) begin
         st_next.res   = ipo_pkg::RES_HUNDREDTH;
         st_next.op_x  = ipo_pkg::OP_RESET;
         st_next.op_y  = ipo_pkg::OP_RESET;
         st_next.pre_x = ipo_pkg::PRESET_RESET;
         st_next.pre_y = ipo_pkg::PRESET_RESET;
         st_next.off_x = FACTORY_OFFSET_X;
         st_next.off_y = FACTORY_OFFSET_Y;
         st_next.dirty = 1'b1;
      end
   end

   // ==========================================================
   // state register
   always_ff @(posedge core_clk) begin
      if (rst) begin
         st_reg       <= '0;
         st_reg.res   <= ipo_pkg::RES_HUNDREDTH;
         st_reg.op_x  <= ipo_pkg::OP_RESET;
         st_reg.op_y  <= ipo_pkg::OP_RESET;
         st_reg.pre_x <= ipo_pkg::PRESET_RESET;
         st_reg.pre_y <= ipo_pkg::PRESET_RESET;
         st_reg.off_x <= FACTORY_OFFSET_X;
         st_reg.off_y <= FACTORY_OFFSET_Y;
      end else begin
         st_reg <= st_next;
      end
   end

   // outputs straight from the state flops
   assign od_rdata       = st_reg.rdata;
   assign od_ack         = st_reg.ack;
   assign od_err         = st_reg.err;
   assign settings_dirty = st_reg.dirty;
   assign tilt_x_out     = st_reg.out_x;
   assign tilt_y_out     = st_reg.out_y;

   // ==========================================================
   // assertions
   property p_res_default;
      @(posedge core_clk) rst |=> (st_reg.res == ipo_pkg::RES_HUNDREDTH);
   endproperty
   a_res_default: assert property (p_res_default) else $error("resolution reset wrong");

   property p_res_illegal;
      @(posedge core_clk) disable iff (rst)
         (wr && sub_plain && od_index == ipo_pkg::IDX_RESOLUTION &&
          !ipo_res_legal(od_wdata) && !load_defaults) |=> (od_err && $stable(st_reg.res));
   endproperty
   a_res_illegal: assert property (p_res_illegal) else $error("bad resolution taken");

   property p_raw_pass;
      @(posedge core_clk) disable iff (rst)
         (!st_reg.op_x[ipo_pkg::OP_PRESET_BIT] && !st_reg.op_x[ipo_pkg::OP_INVERT_BIT] &&
          st_reg.res == ipo_pkg::RES_HUNDREDTH) |=> (tilt_x_out == $past(meas_tilt_x));
   endproperty
   a_raw_pass: assert property (p_raw_pass) else $error("raw x not passed");

   property p_invert;
      @(posedge core_clk) disable iff (rst)
         (st_reg.op_y == 8'h01 && st_reg.res == ipo_pkg::RES_HUNDREDTH &&
          meas_tilt_y != 16'h8000) |=> (tilt_y_out == 16'(-$past(meas_tilt_y)));
   endproperty
   a_invert: assert property (p_invert) else $error("y not inverted");

   property p_op_reset;
      @(posedge core_clk) rst |=> (st_reg.op_x == 8'h02 && st_reg.op_y == 8'h02);
   endproperty
   a_op_reset: assert property (p_op_reset) else $error("operating bits reset wrong");

   property p_preset_reads;
      @(posedge core_clk) disable iff (rst)
         (wr && sub_plain && od_index == ipo_pkg::IDX_X_PRESET && !load_defaults &&
          ipo_in_limit(new_off_x) && st_reg.op_x[ipo_pkg::OP_PRESET_BIT] &&
          $stable(meas_tilt_x)) ##1 $stable(meas_tilt_x) |=> (tilt_x_out == $past(st_reg.pre_x));
   endproperty
   a_preset_reads: assert property (p_preset_reads) else $error("x not at preset");

   property p_defaults;
      @(posedge core_clk) disable iff (rst)
         load_defaults |=> (st_reg.pre_x == 16'h0000 && st_reg.pre_y == 16'h0000 &&
                            st_reg.off_x == FACTORY_OFFSET_X && st_reg.off_y == FACTORY_OFFSET_Y);
   endproperty
   a_defaults: assert property (p_defaults) else $error("defaults not loaded");

   property p_limit;
      @(posedge core_clk) disable iff (rst)
         (wr && sub_plain && od_index == ipo_pkg::IDX_Y_PRESET && !load_defaults &&
          !ipo_in_limit(new_off_y))
         |=> (od_err && $stable(st_reg.pre_y));
   endproperty
   a_limit: assert property (p_limit) else $error("preset beyond limit taken");

   property p_count;
      @(posedge core_clk) disable iff (rst)
         (rd && od_index == ipo_pkg::IDX_ARRAY && od_sub == 8'h00) |=> (od_rdata == 16'h000f);
   endproperty
   a_count: assert property (p_count) else $error("highest subindex wrong");

   property p_reserved;
      @(posedge core_clk) disable iff (rst)
         (rd && od_index == ipo_pkg::IDX_ARRAY && (od_sub inside {[8'h06:8'h09], 8'h0f}))
         |=> (od_rdata == 16'h0000 && !od_err);
   endproperty
   a_reserved: assert property (p_reserved) else $error("reserved channel not zero");

   property p_dirty;
      @(posedge core_clk) disable iff (rst)
         (wr && !od_err ##1 od_ack && !od_err) |-> settings_dirty;
   endproperty
   a_dirty: assert property (p_dirty) else $error("change not marked unsaved");

   c_preset_x: cover property (@(posedge core_clk) disable iff (rst)
      wr && od_index == ipo_pkg::IDX_X_PRESET ##1 !od_err);
   c_res_whole: cover property (@(posedge core_clk) disable iff (rst)
      st_reg.res == ipo_pkg::RES_WHOLE ##1 rd && od_index == ipo_pkg::IDX_Y_OUTPUT);
   c_saturate: cover property (@(posedge core_clk) disable iff (rst)
      tilt_x_out == 16'h7fff);
   c_store: cover property (@(posedge core_clk) disable iff (rst)
      settings_dirty ##1 store_done ##1 !settings_dirty);
endmodule

// [tb/ipo_master_model.sv]
/*
 network master model: issues object dictionary reads and writes and store requests.
 assumes the stage answers one cycle after each request on core_clk.
*/
`timescale 1ns/1ps
module ipo_master_model (
   input  wire logic        core_clk,
   input  wire logic [15:0] od_rdata,
   input  wire logic        od_ack,
   input  wire logic        od_err,
   output logic             od_req,
   output logic             od_write,
   output logic      [15:0] od_index,
   output logic      [7:0]  od_sub,
   output logic      [15:0] od_wdata,
   output logic             store_done
);
   // ==========================================================
   // idle state at time zero
   initial begin
      od_req = 1'b0;
      od_write = 1'b0;
      od_index = 16'h0000;
      od_sub = 8'h00;
      od_wdata = 16'h0000;
      store_done = 1'b0;
   end
   // request held up to the answer edge, then qualifiers inverted so stale values never match
   task automatic access(input logic wr, input logic [15:0] idx, input logic [7:0] sub,
                         input logic [15:0] wd, output logic [15:0] rd, output logic er);
      @(posedge core_clk);
      #1 od_req = 1'b1;
      od_write = wr;
      od_index = idx;
      od_sub = sub;
      od_wdata = wd;
      @(posedge core_clk);
      #1 rd = od_rdata;
      er = od_ack ? od_err : 1'bx; // missing answer shows as unknown
      od_req = 1'b0;
      od_write = ~wr;
      od_index = ~idx;
      od_sub = ~sub;
      od_wdata = ~wd;
   endtask
   // store object completed: settings become non-volatile
   task automatic store();
      @(posedge core_clk);
      #1 store_done = 1'b1;
      @(posedge core_clk);
      #1 store_done = 1'b0;
   endtask
endmodule

// [tb/test_inclination_profile_output.sv]
/*
 self-checking bench for the inclination output stage, narrow two-axis variant.
 assumes ipo_pkg and ipo_core compiled first; master model drives the object port.
*/
`timescale 1ns/1ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin num_errors++; \
   $display("MISMATCH %s exp %h got %h", n, e, g); end end
module test_inclination_profile_output;
   logic core_clk = 1'b0, rst = 1'b1, load_defaults = 1'b0;
   logic od_req, od_write, od_ack, od_err, store_done, settings_dirty;
   logic [15:0] od_index, od_wdata, od_rdata, tilt_x_out, tilt_y_out, d;
   logic [7:0]  od_sub;
   logic [15:0] meas_tilt_x = 16'h0000, meas_tilt_y = 16'h0000, meas_accel_x = 16'h0000;
   logic [15:0] meas_accel_y = 16'h0000, meas_accel_z = 16'h0000, meas_temp_tenth = 16'h0000;
   logic [15:0] meas_full_x = 16'h0000, meas_dev_temp = 16'h0000;
   logic        e;
   int          num_errors = 0, checked = 0;
   always #25 core_clk = ~core_clk;
   ipo_core #(.FACTORY_OFFSET_X(16'h0032), .FACTORY_OFFSET_Y(16'h0000), .NARROW_TWO_AXIS(1'b1))
      i_dut (.core_clk, .rst, .od_req, .od_write, .od_index, .od_sub, .od_wdata, .od_rdata,
             .od_ack, .od_err, .load_defaults, .store_done, .settings_dirty, .meas_tilt_x,
             .meas_tilt_y, .meas_accel_x, .meas_accel_y, .meas_accel_z, .meas_temp_tenth,
             .meas_full_x, .meas_dev_temp, .tilt_x_out, .tilt_y_out);
   ipo_master_model i_mst (.core_clk, .od_rdata, .od_ack, .od_err, .od_req, .od_write,
                           .od_index, .od_sub, .od_wdata, .store_done);
   // ==========================================================
   // helpers: expected axis value, access shorthands
   function automatic logic [15:0] f(int m, bit inv, bit en, int off, int step);
      int v;
      v = inv ? -m : m;
      if (en) v = v + off;
      v = v / step; // truncates toward zero like the stage
      if (v > 32767) v = 32767;
      if (v < -32768) v = -32768;
      return v[15:0];
   endfunction
   task automatic rd(input logic [15:0] i, input logic [7:0] s);
      i_mst.access(1'b0, i, s, 16'h0000, d, e);
   endtask
   task automatic wr(input logic [15:0] i, input logic [15:0] w);
      i_mst.access(1'b1, i, 8'h00, w, d, e);
   endtask
   task automatic settle();
      repeat (2) @(posedge core_clk);
      #1;
   endtask
   task automatic stop_test();
      $display("checked %0d num_errors %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // ==========================================================
   // scenarios
   task automatic t_reset();
      rd(ipo_pkg::IDX_RESOLUTION, 8'h00); `CHK("res", 16'h000a, d)
      rd(ipo_pkg::IDX_X_OPBITS, 8'h00); `CHK("opx", 16'h0002, d)
      rd(ipo_pkg::IDX_Y_OPBITS, 8'h00); `CHK("opy", 16'h0002, d)
      rd(ipo_pkg::IDX_X_PRESET, 8'h00); `CHK("prx", 16'h0000, d)
      rd(ipo_pkg::IDX_ARRAY, 8'h00); `CHK("cnt", 16'h000f, d)
   endtask
   task automatic t_refuse();
      logic [15:0] ro[4] = '{16'h6010, 16'h6020, 16'h6401, 16'h6511};
      for (int k = 0; k < 4; k++) begin
         wr(ro[k], 16'h0001); `CHK("ro_err", 1'b1, e)
      end
      wr(ipo_pkg::IDX_RESOLUTION, 16'h0005); `CHK("res_err", 1'b1, e)
      rd(ipo_pkg::IDX_X_OUTPUT, 8'h01); `CHK("sub_err", 1'b1, e)
      rd(ipo_pkg::IDX_ARRAY, 8'h10); `CHK("arr_err", 1'b1, e)
   endtask
   task automatic t_res();
      logic [15:0] c[3] = '{16'h000a, 16'h0064, 16'h03e8};
      int s[3] = '{1, 10, 100};
      #0 meas_tilt_x = 16'h04d2; // 12.34 degrees
      meas_tilt_y = 16'hfb2e;
      for (int k = 0; k < 3; k++) begin
         wr(ipo_pkg::IDX_RESOLUTION, c[k]); `CHK("res_ok", 1'b0, e)
         settle();
         `CHK("tx", f(1234, 0, 1, 50, s[k]), tilt_x_out)
         `CHK("ty", f(-1234, 0, 1, 0, s[k]), tilt_y_out)
         rd(ipo_pkg::IDX_X_OUTPUT, 8'h00); `CHK("rx", f(1234, 0, 1, 50, s[k]), d)
         rd(ipo_pkg::IDX_Y_OUTPUT, 8'h00); `CHK("ry", f(-1234, 0, 1, 0, s[k]), d)
         rd(ipo_pkg::IDX_ARRAY, 8'h04); `CHK("a4", f(1234, 0, 1, 50, 1), d)
         rd(ipo_pkg::IDX_ARRAY, 8'h05); `CHK("a5", f(-1234, 0, 1, 0, 1), d)
      end
      wr(ipo_pkg::IDX_RESOLUTION, 16'h000a);
   endtask
   task automatic t_invert();
      wr(ipo_pkg::IDX_X_OPBITS, 16'h0003); settle();
      `CHK("inv", f(1234, 1, 1, 50, 1), tilt_x_out)
      wr(ipo_pkg::IDX_X_OPBITS, 16'h0000); settle();
      `CHK("raw", 16'h04d2, tilt_x_out)
      wr(ipo_pkg::IDX_X_OPBITS, 16'h0002);
      // y axis inverted with correction off reads the negated measurement
      wr(ipo_pkg::IDX_Y_OPBITS, 16'h0001); settle();
      `CHK("inv_y", f(-1234, 1, 0, 0, 1), tilt_y_out)
      wr(ipo_pkg::IDX_Y_OPBITS, 16'h0002);
   endtask
   task automatic t_preset();
      wr(ipo_pkg::IDX_X_PRESET, 16'h03e8); `CHK("pr_ok", 1'b0, e)
      settle();
      `CHK("pr_out", 16'h03e8, tilt_x_out)
      rd(ipo_pkg::IDX_X_OFFSET, 8'h00); `CHK("off", 16'hff16, d)
      wr(ipo_pkg::IDX_X_PRESET, 16'h0000); `CHK("pr_err", 1'b1, e)
      rd(ipo_pkg::IDX_X_PRESET, 8'h00); `CHK("pr_kept", 16'h03e8, d)
      // y sits at -12.34 degrees, so a zero preset needs more than 5 degrees
      wr(ipo_pkg::IDX_Y_PRESET, 16'h0000); `CHK("pry_err", 1'b1, e)
      rd(ipo_pkg::IDX_Y_PRESET, 8'h00); `CHK("pry_kept", 16'h0000, d)
   endtask
   task automatic t_sat();
      wr(ipo_pkg::IDX_X_OFFSET, 16'h7fff);
      #0 meas_tilt_x = 16'h7000; settle();
      `CHK("sat_hi", 16'h7fff, tilt_x_out)
      wr(ipo_pkg::IDX_X_OFFSET, 16'h8000);
      #0 meas_tilt_x = 16'h9000; settle();
      `CHK("sat_lo", 16'h8000, tilt_x_out)
   endtask
   task automatic t_array();
      logic [7:0] z[8] = '{8'h06, 8'h07, 8'h08, 8'h09, 8'h0b, 8'h0c, 8'h0d, 8'h0f};
      #0 meas_accel_x = 16'hfa24;
      meas_accel_y = 16'h05dc;
      meas_accel_z = 16'h0123;
      meas_temp_tenth = 16'h00fb;
      meas_full_x = 16'h8ca0;
      meas_dev_temp = 16'h0019;
      rd(ipo_pkg::IDX_ARRAY, 8'h01); `CHK("ax", 16'hfa24, d)
      rd(ipo_pkg::IDX_ARRAY, 8'h02); `CHK("ay", 16'h05dc, d)
      rd(ipo_pkg::IDX_ARRAY, 8'h03); `CHK("az", 16'h0123, d)
      rd(ipo_pkg::IDX_ARRAY, 8'h0a); `CHK("tmp", 16'h00fb, d)
      rd(ipo_pkg::IDX_ARRAY, 8'h0e); `CHK("full", 16'h8ca0, d)
      rd(ipo_pkg::IDX_DEV_TEMP, 8'h00); `CHK("dtmp", 16'h0019, d)
      for (int k = 0; k < 8; k++) begin
         rd(ipo_pkg::IDX_ARRAY, z[k]); `CHK("rsv", 16'h0000, d)
      end
   endtask
   task automatic t_defaults();
      `CHK("dirty", 1'b1, settings_dirty)
      i_mst.store(); settle();
      `CHK("clean", 1'b0, settings_dirty)
      @(posedge core_clk);
      #1 load_defaults = 1'b1;
      @(posedge core_clk);
      #1 load_defaults = 1'b0;
      rd(ipo_pkg::IDX_X_PRESET, 8'h00); `CHK("def_pr", 16'h0000, d)
      rd(ipo_pkg::IDX_X_OFFSET, 8'h00); `CHK("def_off", 16'h0032, d)
      `CHK("def_dirty", 1'b1, settings_dirty)
   endtask
   // ==========================================================
   // main sequence and watchdog
   initial begin
      repeat (5) @(posedge core_clk);
      #1 rst = 1'b0;
      t_reset(); t_refuse(); t_res(); t_invert(); t_preset(); t_sat(); t_array(); t_defaults();
      stop_test();
   end
   initial begin
      #500000;
      num_errors++;
      stop_test();
   end
endmodule
